// >>> cdccf_pkg.sv
// constants for the clock front-end configuration bank
// assumes an APB master with 32-bit data; registers sit at index * 4
package cdccf_pkg;
  localparam int CDCCF_AW = 8;
  localparam int CDCCF_DW = 32;
  // register indices and byte addresses
  localparam logic [7:0] CDCCF_IDX_OSC = 8'h04;
  localparam logic [7:0] CDCCF_IDX_MEMDIV = 8'h05;
  localparam logic [7:0] CDCCF_IDX_HFSEL = 8'h06;
  localparam logic [7:0] CDCCF_IDX_TRIG = 8'h07;
  localparam logic [7:0] CDCCF_IDX_DCHG = 8'h08;
  localparam logic [7:0] CDCCF_IDX_CHG = 8'h09;
  localparam logic [7:0] CDCCF_ADDR_OSC = 8'h10;
  localparam logic [7:0] CDCCF_ADDR_MEMDIV = 8'h14;
  localparam logic [7:0] CDCCF_ADDR_HFSEL = 8'h18;
  localparam logic [7:0] CDCCF_ADDR_TRIG = 8'h1C;
  localparam logic [7:0] CDCCF_ADDR_DCHG = 8'h20;
  localparam logic [7:0] CDCCF_ADDR_CHG = 8'h24;
  // reset values
  localparam logic [7:0] CDCCF_RST_OSC = 8'h00;
  localparam logic [7:0] CDCCF_RST_MEMDIV = 8'h00;
  localparam logic [7:0] CDCCF_RST_HFSEL = 8'h00;
  localparam logic [7:0] CDCCF_RST_TRIG = 8'h00;
  localparam logic [7:0] CDCCF_RST_DCHG = 8'h00;
  localparam logic [7:0] CDCCF_RST_CHG = 8'h00;
  // writable bits per register
  localparam logic [7:0] CDCCF_MSK_OSC = 8'hFF;
  localparam logic [7:0] CDCCF_MSK_MEMDIV = 8'h3F;
  localparam logic [7:0] CDCCF_MSK_HFSEL = 8'h07;
  localparam logic [7:0] CDCCF_MSK_TRIG = 8'h1F;
  localparam logic [7:0] CDCCF_MSK_DCHG = 8'hFB;
  localparam logic [7:0] CDCCF_MSK_CHG = 8'h7F;
  // oscillator_control fields
  localparam int CDCCF_B_OSC_DIS = 7;
  localparam int CDCCF_B_OSC_TRIM = 6;
  localparam int CDCCF_B_OSC_DIV4 = 5;
  localparam int CDCCF_B_OSC_AUTOHALT = 4;
  localparam int CDCCF_B_OSC_HALT = 3;
  // trigger_symmetry_config fields
  localparam int CDCCF_B_DUMMY_DIS = 4;
  localparam int CDCCF_B_TRIG_SYM = 3;
  localparam int CDCCF_B_SENSE_INV = 2;
  // discharge_resistor_config fields
  localparam int CDCCF_B_RES_UP = 6;
  localparam int CDCCF_B_RES_LO = 4;
  localparam int CDCCF_B_INT_EN = 3;
  localparam int CDCCF_B_EXT_EN = 1;
  localparam int CDCCF_B_MEG_EN = 0;
  // charge_aux_config fields
  localparam int CDCCF_B_AUX_PD_OFF = 6;
  localparam int CDCCF_B_AUX_CAP = 5;
  localparam int CDCCF_B_EARLY = 4;
  localparam int CDCCF_B_PERM_EN = 3;
  localparam int CDCCF_B_EXT_PERM = 2;
  // run modes and warm-up latencies in low-frequency periods
  localparam logic [2:0] CDCCF_RUN_OFF = 3'h0;
  localparam logic [2:0] CDCCF_RUN_PERM = 3'h1;
  localparam logic [2:0] CDCCF_RUN_LAT1 = 3'h6;
  localparam logic [2:0] CDCCF_RUN_LAT2 = 3'h3;
  localparam logic [2:0] CDCCF_RUN_LAT31 = 3'h2;
  localparam logic [4:0] CDCCF_LAT1 = 5'h01;
  localparam logic [4:0] CDCCF_LAT2 = 5'h02;
  localparam logic [4:0] CDCCF_LAT31 = 5'h1F;
  // high-frequency source codes
  localparam logic [2:0] CDCCF_HF_INT1 = 3'h1;
  localparam logic [2:0] CDCCF_HF_INT2 = 3'h2;
  localparam logic [2:0] CDCCF_HF_EXT = 3'h4;
  typedef enum logic [2:0] {
    CDCCF_S_IDLE = 3'b001,
    CDCCF_S_WARM = 3'b010,
    CDCCF_S_ACTIVE = 3'b100
  } cdccf_state_t;
endpackage

// >>> cdccf_top.sv
// clock front-end and analog front-end configuration bank with APB slave
// assumes all inputs synchronous to CLK_SYS and low-frequency and raw
// oscillator levels much slower than CLK_SYS
`timescale 1ns/1ps

// Overview of operation
// (RL1) disable bit stops external oscillator
// (RL2) trim bit picks low or high gain
// (RL3) divide bit quarters oscillator clock
// (RL4) run field: off, permanent, three latencies
// (RL5) pulsed mode warms oscillator before measurement
// (RL6) memory clock divided from low-frequency clock
// (RL7) software picks divider for nominal rate
// (RL8) source field picks internal or external clock
// (RL9) dummy-disable bit omits symmetry cycles
// (RL10) invert bit flips trigger level to converter
// (RL11) software leaves trigger select at zero
// (RL12) upper group discharge resistor select
// (RL13) lower and special group resistor select
// (RL14) megaohm bit replaces lower path resistor
// (RL15) aux bit drops pull-downs, activates port
// (RL16) early-open bit releases internal resistor early
// (RL17) charging resistor select
// (RL18) software keeps internal oscillator bits zero
// (RL19) separate enables for discharge paths
module cdccf_top
  import cdccf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [CDCCF_AW-1:0] PADDR,
  input wire logic [CDCCF_DW-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [CDCCF_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LOW_FREQ_CLK,
  input wire logic EXT_OSC_RAW,
  input wire logic MEAS_REQ,
  input wire logic MEAS_DONE,
  input wire logic TRIG_IN,
  output logic EXT_OSC_EN,
  output logic EXT_OSC_GAIN_HIGH,
  output logic EXT_OSC_CLK,
  output logic EXT_OSC_AUTOHALT_OFF,
  output logic EXT_OSC_HALT,
  output logic MEAS_START,
  output logic MEM_CLK,
  output logic [2:0] HF_SOURCE_SEL,
  output logic DUMMY_CYCLE_EN,
  output logic TRIG_DUMMY_SYM_EN,
  output logic SENSE_OUT,
  output logic [1:0] TRIGGER_SELECT,
  output logic [3:0] DISCHARGE_RES_UPPER,
  output logic [3:0] DISCHARGE_RES_LOWER,
  output logic MEGAOHM_DISCHARGE_SEL,
  output logic INTERNAL_DISCHARGE_EN,
  output logic EXTERNAL_DISCHARGE_EN,
  output logic AUX_PORT_PULLDOWN_EN,
  output logic AUX_INTERNAL_CAP,
  output logic DISCHARGE_EARLY_RELEASE,
  output logic DISCHARGE_PERMANENT_EN,
  output logic EXTERNAL_DISCHARGE_PERMANENT,
  output logic [3:0] CHARGE_RES_SEL
);

  // 2-bit resistor code to one-hot leg: 0=180k 1=90k 2=30k 3=10k
  function automatic logic [3:0] res_onehot(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h0;
    r[code] = 1'b1;
    return r;
  endfunction

  // warm-up length for a pulsed run code, zero when not pulsed
  function automatic logic [4:0] run_latency(input logic [2:0] mode);
    logic [4:0] l;
    l = 5'h00;
    case (mode)
      CDCCF_RUN_LAT1: l = CDCCF_LAT1;
      CDCCF_RUN_LAT2: l = CDCCF_LAT2;
      CDCCF_RUN_LAT31: l = CDCCF_LAT31;
      default: l = 5'h00;
    endcase
    return l;
  endfunction

  // address decode, used only for the error response; read mux and write path decode separately
  function automatic logic addr_hit(input logic [7:0] a);
    logic h;
    h = 1'b0;
    case (a)
      CDCCF_ADDR_OSC, CDCCF_ADDR_MEMDIV, CDCCF_ADDR_HFSEL,
      CDCCF_ADDR_TRIG, CDCCF_ADDR_DCHG, CDCCF_ADDR_CHG: h = 1'b1;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  logic [7:0] osc_q;
  logic [7:0] memdiv_q;
  logic [7:0] hfsel_q;
  logic [7:0] trig_q;
  logic [7:0] dchg_q;
  logic [7:0] chg_q;
  logic pready_q;
  logic pslverr_q;
  logic [CDCCF_DW-1:0] prdata_q;
  logic [7:0] rdata_d;
  logic wr_en;
  logic [7:0] wbyte;

  // ---------------- APB slave ----------------
  // one wait-free access: ready rises in the first access cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (PSEL && !PENABLE && !pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !addr_hit(PADDR);
      prdata_q <= (PWRITE) ? 32'h00000000 : {24'h000000, rdata_d};
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
  end

  always_comb
  begin
    case (PADDR)
      CDCCF_ADDR_OSC: rdata_d = osc_q;
      CDCCF_ADDR_MEMDIV: rdata_d = memdiv_q;
      CDCCF_ADDR_HFSEL: rdata_d = hfsel_q;
      CDCCF_ADDR_TRIG: rdata_d = trig_q;
      CDCCF_ADDR_DCHG: rdata_d = dchg_q;
      CDCCF_ADDR_CHG: rdata_d = chg_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // only lane 0 carries data; upper lanes are ignored
  assign wr_en = PSEL && PENABLE && pready_q && PWRITE && PSTRB[0];
  assign wbyte = PWDATA[7:0];

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      osc_q <= CDCCF_RST_OSC;
      memdiv_q <= CDCCF_RST_MEMDIV;
      hfsel_q <= CDCCF_RST_HFSEL;
      trig_q <= CDCCF_RST_TRIG;
      dchg_q <= CDCCF_RST_DCHG;
      chg_q <= CDCCF_RST_CHG;
    end
    else if (wr_en)
    begin
      case (PADDR)
        CDCCF_ADDR_OSC: osc_q <= wbyte & CDCCF_MSK_OSC;
        CDCCF_ADDR_MEMDIV: memdiv_q <= wbyte & CDCCF_MSK_MEMDIV;
        CDCCF_ADDR_HFSEL: hfsel_q <= wbyte & CDCCF_MSK_HFSEL;
        CDCCF_ADDR_TRIG: trig_q <= wbyte & CDCCF_MSK_TRIG;
        CDCCF_ADDR_DCHG: dchg_q <= wbyte & CDCCF_MSK_DCHG;
        CDCCF_ADDR_CHG: chg_q <= wbyte & CDCCF_MSK_CHG;
        default: ;
      endcase
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // ---------------- edge detection on slow inputs ----------------
  logic lf_prev_q;
  logic raw_prev_q;
  logic lf_rise;
  logic raw_rise;

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      lf_prev_q <= 1'b0;
      raw_prev_q <= 1'b0;
    end
    else
    begin
      lf_prev_q <= LOW_FREQ_CLK;
      raw_prev_q <= EXT_OSC_RAW;
    end
  end

  assign lf_rise = LOW_FREQ_CLK && !lf_prev_q;
  assign raw_rise = EXT_OSC_RAW && !raw_prev_q;

  // ---------------- oscillator run control ----------------
  logic [2:0] run_mode;
  logic osc_disable;
  logic pulsed;
  cdccf_state_t state_q;
  cdccf_state_t state_d;
  logic [4:0] warm_cnt_q;
  logic [4:0] warm_cnt_d;
  logic start_d;
  logic start_q;

  assign run_mode = osc_q[2:0];
  assign osc_disable = osc_q[CDCCF_B_OSC_DIS];
  // (RL4) pulsed codes
  assign pulsed = (run_latency(run_mode) != 5'h00);

  always_comb
  begin
    state_d = state_q;
    warm_cnt_d = warm_cnt_q;
    start_d = 1'b0;
    case (state_q)
      CDCCF_S_IDLE:
      begin
        if (MEAS_REQ)
        begin
          // (RL5) warm up ahead
          if (pulsed && !osc_disable)
          begin
            state_d = CDCCF_S_WARM;
            warm_cnt_d = 5'h00;
          end
          else
          begin
            state_d = CDCCF_S_ACTIVE;
            start_d = 1'b1;
          end
        end
      end
      CDCCF_S_WARM:
      begin
        // (RL5) count latency periods
        if (lf_rise)
        begin
          warm_cnt_d = warm_cnt_q + 5'h01;
          if (warm_cnt_q + 5'h01 >= run_latency(run_mode))
          begin
            state_d = CDCCF_S_ACTIVE;
            start_d = 1'b1;
          end
        end
      end
      CDCCF_S_ACTIVE:
      begin
        if (MEAS_DONE)
        begin
          state_d = CDCCF_S_IDLE;
        end
      end
      default:
      begin
        state_d = CDCCF_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_q <= CDCCF_S_IDLE;
      warm_cnt_q <= 5'h00;
      start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      warm_cnt_q <= warm_cnt_d;
      start_q <= start_d;
    end
  end

  assign MEAS_START = start_q;

  logic osc_en_d;
  logic osc_en_q;
  logic gain_q;
  logic autohalt_q;
  logic halt_q;

  // (RL1) disable bit overrides every run mode
  // (RL4) permanent runs always, pulsed only around a measurement
  assign osc_en_d = !osc_disable &&
                    ((run_mode == CDCCF_RUN_PERM) ||
                     (pulsed && (state_q != CDCCF_S_IDLE)));

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      osc_en_q <= 1'b0;
      gain_q <= 1'b0;
      autohalt_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      osc_en_q <= osc_en_d;
      // (RL2) gain trim
      gain_q <= osc_q[CDCCF_B_OSC_TRIM];
      autohalt_q <= osc_q[CDCCF_B_OSC_AUTOHALT];
      halt_q <= osc_q[CDCCF_B_OSC_HALT];
    end
  end

  assign EXT_OSC_EN = osc_en_q;
  assign EXT_OSC_GAIN_HIGH = gain_q;
  assign EXT_OSC_AUTOHALT_OFF = autohalt_q;
  assign EXT_OSC_HALT = halt_q;

  // ---------------- oscillator clock output ----------------
  logic div_ph_q;
  logic osc_clk_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      div_ph_q <= 1'b0;
      osc_clk_q <= 1'b0;
    end
    else if (!osc_en_q)
    begin
      div_ph_q <= 1'b0;
      osc_clk_q <= 1'b0;
    end
    // (RL3) toggle every second raw rising edge
    else if (osc_q[CDCCF_B_OSC_DIV4])
    begin
      if (raw_rise)
      begin
        div_ph_q <= !div_ph_q;
        if (div_ph_q)
        begin
          osc_clk_q <= !osc_clk_q;
        end
      end
    end
    else
    begin
      osc_clk_q <= EXT_OSC_RAW;
    end
  end

  assign EXT_OSC_CLK = osc_clk_q;

  // ---------------- memory clock divider ----------------
  // output period is 2*n low-frequency periods, n=0 passes straight
  logic [5:0] mem_n;
  logic [5:0] mem_cnt_q;
  logic mem_clk_q;

  assign mem_n = memdiv_q[5:0];

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      mem_cnt_q <= 6'h00;
      mem_clk_q <= 1'b0;
    end
    // (RL6) no division at zero
    else if (mem_n == 6'h00)
    begin
      mem_cnt_q <= 6'h00;
      mem_clk_q <= LOW_FREQ_CLK;
    end
    // (RL6) half period of n ticks
    else if (lf_rise)
    begin
      if (mem_cnt_q >= mem_n - 6'h01)
      begin
        mem_cnt_q <= 6'h00;
        mem_clk_q <= !mem_clk_q;
      end
      else
      begin
        mem_cnt_q <= mem_cnt_q + 6'h01;
      end
    end
  end

  assign MEM_CLK = mem_clk_q;

  // ---------------- clock source and trigger options ----------------
  logic [2:0] hf_sel_q;
  logic dummy_en_q;
  logic trig_sym_q;
  logic sense_q;
  logic [1:0] trig_sel_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      hf_sel_q <= 3'h0;
      dummy_en_q <= 1'b0;
      trig_sym_q <= 1'b0;
      sense_q <= 1'b0;
      trig_sel_q <= 2'h0;
    end
    else
    begin
      // (RL8) only the three defined codes select a source
      hf_sel_q[0] <= (hfsel_q[2:0] == CDCCF_HF_INT1);
      hf_sel_q[1] <= (hfsel_q[2:0] == CDCCF_HF_INT2);
      hf_sel_q[2] <= (hfsel_q[2:0] == CDCCF_HF_EXT);
      // (RL9) zero enables dummy cycles
      dummy_en_q <= !trig_q[CDCCF_B_DUMMY_DIS];
      trig_sym_q <= trig_q[CDCCF_B_TRIG_SYM];
      // (RL10) invert trigger level
      sense_q <= TRIG_IN ^ trig_q[CDCCF_B_SENSE_INV];
      trig_sel_q <= trig_q[1:0];
    end
  end

  assign HF_SOURCE_SEL = hf_sel_q;
  assign DUMMY_CYCLE_EN = dummy_en_q;
  assign TRIG_DUMMY_SYM_EN = trig_sym_q;
  assign SENSE_OUT = sense_q;
  assign TRIGGER_SELECT = trig_sel_q;

  // ---------------- resistor network ----------------
  logic [3:0] res_up_q;
  logic [3:0] res_lo_q;
  logic meg_q;
  logic [3:0] chg_res_q;
  logic int_en_q;
  logic ext_en_q;
  logic perm_q;
  logic ext_perm_q;
  logic aux_pd_q;
  logic aux_cap_q;
  logic early_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      res_up_q <= 4'h0;
      res_lo_q <= 4'h0;
      meg_q <= 1'b0;
      chg_res_q <= 4'h0;
    end
    else
    begin
      // (RL12) upper group select
      res_up_q <= res_onehot(dchg_q[CDCCF_B_RES_UP +: 2]);
      // (RL13) (RL14) megaohm replaces lower leg only
      res_lo_q <= dchg_q[CDCCF_B_MEG_EN] ? 4'h0 :
                  res_onehot(dchg_q[CDCCF_B_RES_LO +: 2]);
      meg_q <= dchg_q[CDCCF_B_MEG_EN];
      // (RL17) charging resistor
      chg_res_q <= res_onehot(chg_q[1:0]);
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      int_en_q <= 1'b0;
      ext_en_q <= 1'b0;
      perm_q <= 1'b0;
      ext_perm_q <= 1'b0;
      aux_pd_q <= 1'b1;
      aux_cap_q <= 1'b0;
      early_q <= 1'b0;
    end
    else
    begin
      // (RL19) discharge path enables
      int_en_q <= dchg_q[CDCCF_B_INT_EN];
      ext_en_q <= dchg_q[CDCCF_B_EXT_EN];
      perm_q <= chg_q[CDCCF_B_PERM_EN];
      ext_perm_q <= chg_q[CDCCF_B_EXT_PERM];
      // (RL15) pull-downs stay on until port activated
      aux_pd_q <= !chg_q[CDCCF_B_AUX_PD_OFF];
      aux_cap_q <= chg_q[CDCCF_B_AUX_CAP];
      // (RL16) early release
      early_q <= chg_q[CDCCF_B_EARLY];
    end
  end

  assign DISCHARGE_RES_UPPER = res_up_q;
  assign DISCHARGE_RES_LOWER = res_lo_q;
  assign MEGAOHM_DISCHARGE_SEL = meg_q;
  assign CHARGE_RES_SEL = chg_res_q;
  assign INTERNAL_DISCHARGE_EN = int_en_q;
  assign EXTERNAL_DISCHARGE_EN = ext_en_q;
  assign DISCHARGE_PERMANENT_EN = perm_q;
  assign EXTERNAL_DISCHARGE_PERMANENT = ext_perm_q;
  assign AUX_PORT_PULLDOWN_EN = aux_pd_q;
  assign AUX_INTERNAL_CAP = aux_cap_q;
  assign DISCHARGE_EARLY_RELEASE = early_q;

endmodule

// >>> cdccf_top_properties.sv
// concurrent checks for the clock front-end configuration bank
// assumes binding to cdccf_top; sees only that module's ports
`timescale 1ns/1ps
module cdccf_chk
  import cdccf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [CDCCF_AW-1:0] PADDR,
  input wire logic [CDCCF_DW-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [CDCCF_DW-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TRIG_IN,
  input wire logic EXT_OSC_EN,
  input wire logic EXT_OSC_GAIN_HIGH,
  input wire logic MEAS_START,
  input wire logic [2:0] HF_SOURCE_SEL,
  input wire logic SENSE_OUT,
  input wire logic [3:0] DISCHARGE_RES_UPPER,
  input wire logic [3:0] DISCHARGE_RES_LOWER,
  input wire logic MEGAOHM_DISCHARGE_SEL,
  input wire logic AUX_PORT_PULLDOWN_EN
);
  logic wr;
  logic [7:0] osc_q, hf_q, trig_q, dchg_q, chg_q;
  assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  // shadow copies let output checks span the whole write path
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      osc_q <= 8'h00;
      hf_q <= 8'h00;
      trig_q <= 8'h00;
      dchg_q <= 8'h00;
      chg_q <= 8'h00;
    end
    else if (wr)
    begin
      if (PADDR == CDCCF_ADDR_OSC) osc_q <= PWDATA[7:0];
      if (PADDR == CDCCF_ADDR_HFSEL) hf_q <= PWDATA[7:0];
      if (PADDR == CDCCF_ADDR_TRIG) trig_q <= PWDATA[7:0];
      if (PADDR == CDCCF_ADDR_DCHG) dchg_q <= PWDATA[7:0];
      if (PADDR == CDCCF_ADDR_CHG) chg_q <= PWDATA[7:0];
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  chk_ready_after_setup:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  chk_ready_one_cycle:
    assert property (PREADY |=> !PREADY) else $error("ready too long");
  chk_err_with_ready:
    assert property (PSLVERR |-> PREADY) else $error("lone error");
  chk_rdata_idle_zero:
    assert property (!PREADY |-> PRDATA == 32'h0) else $error("rdata idle");
  chk_osc_stopped:
    assert property (osc_q[7] && $past(osc_q[7]) |-> !EXT_OSC_EN)
      else $error("osc runs while disabled");
  chk_gain_follows:
    assert property (wr && PADDR == CDCCF_ADDR_OSC |->
      ##2 EXT_OSC_GAIN_HIGH == $past(PWDATA[6], 2)) else $error("gain");
  chk_start_pulse:
    assert property (MEAS_START |=> !MEAS_START) else $error("start long");
  chk_hf_decode:
    assert property (!$past(SYS_RST) |-> HF_SOURCE_SEL ==
      {$past(hf_q[2:0]) == 3'h4, $past(hf_q[2:0]) == 3'h2,
       $past(hf_q[2:0]) == 3'h1}) else $error("hf select");
  chk_sense_invert:
    assert property (!$past(SYS_RST) |->
      SENSE_OUT == ($past(TRIG_IN) ^ $past(trig_q[2]))) else $error("sense");
  chk_upper_res:
    assert property (!$past(SYS_RST) |->
      DISCHARGE_RES_UPPER == (4'h1 << $past(dchg_q[7:6])))
      else $error("upper resistor");
  chk_megaohm_lower:
    assert property (MEGAOHM_DISCHARGE_SEL |-> DISCHARGE_RES_LOWER == 4'h0)
      else $error("lower resistor");
  chk_aux_pulldown:
    assert property (!$past(SYS_RST) |->
      AUX_PORT_PULLDOWN_EN == !$past(chg_q[6])) else $error("aux pulldown");
  cover property (wr);
  cover property (PSLVERR);
  cover property (MEAS_START && EXT_OSC_EN);
endmodule

bind cdccf_top cdccf_chk cdccf_chk_i (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_IN(TRIG_IN),
  .EXT_OSC_EN(EXT_OSC_EN), .EXT_OSC_GAIN_HIGH(EXT_OSC_GAIN_HIGH),
  .MEAS_START(MEAS_START), .HF_SOURCE_SEL(HF_SOURCE_SEL),
  .SENSE_OUT(SENSE_OUT), .DISCHARGE_RES_UPPER(DISCHARGE_RES_UPPER),
  .DISCHARGE_RES_LOWER(DISCHARGE_RES_LOWER),
  .MEGAOHM_DISCHARGE_SEL(MEGAOHM_DISCHARGE_SEL),
  .AUX_PORT_PULLDOWN_EN(AUX_PORT_PULLDOWN_EN)
);

// >>> cdccf_top_tb.sv
// self-checking bench for the clock front-end configuration bank
// assumes cdccf_top with its checker bound; bench drives every port
`timescale 1ns/1ps
module cdccf_top_tb
  import cdccf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] lf_div = 4'h0;
  logic meas_req = 1'b0, meas_done = 1'b0, trig_in = 1'b0;
  logic pready, pslverr, osc_en, gain, osc_clk, autohalt, halt;
  logic meas_start, mem_clk, dummy_en, sym_en, sense, meg, int_en, ext_en;
  logic pd_en, aux_cap, early, perm_en, ext_perm;
  logic [2:0] hf_sel;
  logic [1:0] trig_sel;
  logic [3:0] res_up, res_lo, chg_sel;
  int num_errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  // low-frequency clock is clk/16, raw oscillator clk/8
  always @(posedge clk) lf_div <= lf_div + 4'h1;
  cdccf_top cdccf_top_i (
    .CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LOW_FREQ_CLK(lf_div[3]), .EXT_OSC_RAW(lf_div[2]),
    .MEAS_REQ(meas_req), .MEAS_DONE(meas_done), .TRIG_IN(trig_in),
    .EXT_OSC_EN(osc_en), .EXT_OSC_GAIN_HIGH(gain), .EXT_OSC_CLK(osc_clk),
    .EXT_OSC_AUTOHALT_OFF(autohalt), .EXT_OSC_HALT(halt),
    .MEAS_START(meas_start), .MEM_CLK(mem_clk), .HF_SOURCE_SEL(hf_sel),
    .DUMMY_CYCLE_EN(dummy_en), .TRIG_DUMMY_SYM_EN(sym_en),
    .SENSE_OUT(sense), .TRIGGER_SELECT(trig_sel),
    .DISCHARGE_RES_UPPER(res_up), .DISCHARGE_RES_LOWER(res_lo),
    .MEGAOHM_DISCHARGE_SEL(meg), .INTERNAL_DISCHARGE_EN(int_en),
    .EXTERNAL_DISCHARGE_EN(ext_en), .AUX_PORT_PULLDOWN_EN(pd_en),
    .AUX_INTERNAL_CAP(aux_cap), .DISCHARGE_EARLY_RELEASE(early),
    .DISCHARGE_PERMANENT_EN(perm_en),
    .EXTERNAL_DISCHARGE_PERMANENT(ext_perm), .CHARGE_RES_SEL(chg_sel)
  );
  task automatic report_and_stop();
    $display("comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // write, then let the config outputs catch up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
    repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
    chb(er, ee);
  endtask
  task automatic t_regs();
    logic [7:0] ad [6] = '{CDCCF_ADDR_OSC, CDCCF_ADDR_MEMDIV,
      CDCCF_ADDR_HFSEL, CDCCF_ADDR_TRIG, CDCCF_ADDR_DCHG, CDCCF_ADDR_CHG};
    logic [7:0] mk [6] = '{CDCCF_MSK_OSC, CDCCF_MSK_MEMDIV, CDCCF_MSK_HFSEL,
      CDCCF_MSK_TRIG, CDCCF_MSK_DCHG, CDCCF_MSK_CHG};
    repeat (2) @(posedge clk);
    chk({18'h0, pd_en, dummy_en, res_up, res_lo, chg_sel},
      {18'h0, 2'b11, 12'h111});
    for (int i = 0; i < 6; i++)
    begin
      rdc(ad[i], 32'h0, 1'b0);
      wr(ad[i], 32'hFFFF_FFFF);
      rdc(ad[i], {24'h0, mk[i]}, 1'b0);
      wr(ad[i], 32'h0);
    end
    // a write without the low strobe must leave the register alone
    pstrb <= 4'hE;
    wr(CDCCF_ADDR_OSC, 32'hFF);
    rdc(CDCCF_ADDR_OSC, 32'h0, 1'b0);
    pstrb <= 4'hF;
    wr(8'h00, 32'hFF);
    rdc(8'h00, 32'h0, 1'b1);
    rdc(8'h11, 32'h0, 1'b1);
    rdc(8'h28, 32'h0, 1'b1);
  endtask
  task automatic t_fields();
    logic [1:0] k;
    logic [2:0] c;
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      wr(CDCCF_ADDR_OSC, {25'h0, k[0], 1'b0, k[1], k[0] ^ k[1], 3'h0});
      chk({29'h0, gain, autohalt, halt}, {29'h0, k[0], k[1], ^k});
      wr(CDCCF_ADDR_DCHG, {24'h0, k, ~k, 4'hA});
      chk({21'h0, res_up, res_lo, meg, int_en, ext_en},
        {21'h0, 4'h1 << k, 4'h1 << ~k, 3'b011});
      wr(CDCCF_ADDR_DCHG, {24'h0, k, ~k, 4'h1});
      chk({21'h0, res_up, res_lo, meg, int_en, ext_en},
        {21'h0, 4'h1 << k, 4'h0, 3'b100});
      wr(CDCCF_ADDR_CHG, {24'h0, 2'b01, k[0], 1'b1, k[1], ~k[0], k});
      chk({23'h0, pd_en, aux_cap, early, perm_en, ext_perm, chg_sel},
        {23'h0, 1'b0, k[0], 1'b1, k[1], ~k[0], 4'h1 << k});
      trig_in <= k[1];
      wr(CDCCF_ADDR_TRIG, {27'h0, k[0], k[1], k[0], k});
      chk({27'h0, dummy_en, sym_en, trig_sel, sense},
        {27'h0, ~k[0], k[1], k, ^k});
    end
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr(CDCCF_ADDR_HFSEL, {29'h0, c});
      chk({29'h0, hf_sel}, {29'h0, c == 3'h4, c == 3'h2, c == 3'h1});
    end
  endtask
  task automatic t_meas();
    logic [7:0] v [6] = '{8'h00, 8'h01, 8'h06, 8'h03, 8'h02, 8'h83};
    int lat [6] = '{0, 0, 1, 2, 31, 0};
    int n, rises;
    logic prev, en_s;
    for (int i = 0; i < 6; i++)
    begin
      wr(CDCCF_ADDR_OSC, {24'h0, v[i]});
      // request well clear of a low-frequency rise
      while (lf_div != 4'h2)
        @(posedge clk);
      meas_req <= 1'b1;
      @(posedge clk);
      meas_req <= 1'b0;
      n = 0;
      rises = 0;
      prev = lf_div[3];
      while (meas_start !== 1'b1 && n < 700)
      begin
        @(posedge clk);
        n++;
        if (lf_div[3] && !prev)
          rises++;
        prev = lf_div[3];
      end
      en_s = osc_en;
      chk(rises, lat[i]);
      meas_done <= 1'b1;
      @(posedge clk);
      meas_done <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, en_s, osc_en}, {30'h0, v[i] == 8'h01 || lat[i] > 0,
        v[i] == 8'h01});
    end
  endtask
  task automatic count(input logic s_mem, input int cyc, output int c);
    logic p;
    c = 0;
    p = s_mem ? mem_clk : osc_clk;
    repeat (cyc)
    begin
      @(posedge clk);
      if ((s_mem ? mem_clk : osc_clk) && !p)
        c++;
      p = s_mem ? mem_clk : osc_clk;
    end
  endtask
  task automatic t_clocks();
    logic [7:0] ad [6] = '{CDCCF_ADDR_OSC, CDCCF_ADDR_OSC, CDCCF_ADDR_OSC,
      CDCCF_ADDR_MEMDIV, CDCCF_ADDR_MEMDIV, CDCCF_ADDR_MEMDIV};
    logic [7:0] d [6] = '{8'h21, 8'h01, 8'h81, 8'h00, 8'h02, 8'h3F};
    int cyc [6] = '{320, 320, 320, 320, 640, 4200};
    int e [6] = '{10, 40, 0, 20, 10, 2};
    int c;
    for (int i = 0; i < 6; i++)
    begin
      wr(ad[i], {24'h0, d[i]});
      count(i > 2, cyc[i], c);
      chb(c >= e[i] - 1 && c <= e[i] + 1, 1'b1);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fields();
    t_meas();
    t_clocks();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule
